// ===== src/chan_cfg_defs.svh
`ifndef CHAN_CFG_DEFS_SVH
`define CHAN_CFG_DEFS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define ANA_OUT_IDX        6'h06
`define SENSOR_IDX         6'h07
`define SWITCH_IDX         6'h08

// ==========================================================
// Reset values
`define ANA_OUT_RST        16'h0000
`define SENSOR_RST         16'h0001
`define SWITCH_RST         16'h2E00

// ==========================================================
// Writable bit masks; everything else reads as zero
`define ANA_OUT_MASK       16'h00FF
`define SENSOR_MASK        16'h000F
`define SWITCH_MASK        16'h3FF1

// ==========================================================
// Field positions
`define SPAN_BIT           7
`define SLEW_SEL_LSB       5
`define STEP_SEL_LSB       3
`define RATE_SEL_LSB       1
`define ILIM_BIT           0
`define WIRING_BIT         3
`define SWAP_BIT           2
`define EXC_SEL_LSB        0
`define T2_CODE_LSB        9
`define T1_CODE_LSB        4
`define PUSH_PULL_BIT      0

// ==========================================================
// Slew step sizes in tenths of a percent of full scale
`define STEP_PCT10_0       8
`define STEP_PCT10_1       15
`define STEP_PCT10_2       61
`define STEP_PCT10_3       222
// Slew update rates in Hz
`define RATE_HZ_0          4000
`define RATE_HZ_1          64000
`define RATE_HZ_2          150000
`define RATE_HZ_3          240000
// Excitation currents in microamps
`define EXC_UA_0           11'd250
`define EXC_UA_1           11'd500
`define EXC_UA_2           11'd750
`define EXC_UA_3           11'd1000

// ==========================================================
// Clock and first fault timer durations in ns, codes 1 to 22
`define CLK_HZ             50000000
`define CLK_PERIOD_NS      20
`define T1_NS_01           18699
`define T1_NS_02           24390
`define T1_NS_03           32520
`define T1_NS_04           42276
`define T1_NS_05           56097
`define T1_NS_06           75609
`define T1_NS_07           100812
`define T1_NS_08           130080
`define T1_NS_09           180486
`define T1_NS_10           240648
`define T1_NS_11           320322
`define T1_NS_12           420321
`define T1_NS_13           560157
`define T1_NS_14           750399
`define T1_NS_15           1000803
`define T1_NS_16           1300800
`define T1_NS_17           1800795
`define T1_NS_18           2400789
`define T1_NS_19           3200781
`define T1_NS_20           4200771
`define T1_NS_21           5600757
`define T1_NS_22           7500738

`endif

// ===== src/chan_cfg_pkg.sv
`include "chan_cfg_defs.svh"

package chan_cfg_pkg;

  typedef enum logic [1:0] {
    SLEW_OFF,
    SLEW_LINEAR,
    SLEW_HART,
    SLEW_RSVD
  } slew_mode_e;

  typedef enum logic [1:0] {
    FT_IDLE,
    FT_TIMING,
    FT_EXPIRED
  } fault_state_e;

  typedef struct packed {
    logic       span_bipolar;
    slew_mode_e slew;
    logic [1:0] step_sel;
    logic [1:0] rate_sel;
    logic       ilim_low;
  } ana_out_s;

  typedef struct packed {
    logic       four_wire;
    logic       swap;
    logic [1:0] exc_sel;
  } sensor_s;

endpackage : chan_cfg_pkg

// ===== src/channel_output_and_sensor_config.sv
`timescale 1ns/1ps
`include "chan_cfg_defs.svh"

module channel_output_and_sensor_config
  import chan_cfg_pkg::*;
#(
  parameter int unsigned ADDR_W      = 8,
  parameter int unsigned DAC_W       = 14,
  parameter int unsigned CLK_HZ      = `CLK_HZ,
  parameter int unsigned RATE_DIV_0  = CLK_HZ / `RATE_HZ_0,
  parameter int unsigned RATE_DIV_1  = CLK_HZ / `RATE_HZ_1,
  parameter int unsigned RATE_DIV_2  = CLK_HZ / `RATE_HZ_2,
  parameter int unsigned RATE_DIV_3  = CLK_HZ / `RATE_HZ_3,
  parameter int unsigned T1_TICK_NS  = `CLK_PERIOD_NS,
  parameter logic [1:0]  HART_STEP   = 2'h0,
  parameter logic [1:0]  HART_RATE   = 2'h0
) (
  input  wire logic              aclk,               // System clock
  input  wire logic              aresetn,            // Synchronous reset, low
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,       // Write address
  input  wire logic [2:0]        s_axi_awprot,       // Write protection, unused
  input  wire logic              s_axi_awvalid,      // Write address valid
  output logic                   s_axi_awready,      // Write address ready
  input  wire logic [31:0]       s_axi_wdata,        // Write data
  input  wire logic [3:0]        s_axi_wstrb,        // Write byte strobes
  input  wire logic              s_axi_wvalid,       // Write data valid
  output logic                   s_axi_wready,       // Write data ready
  output logic [1:0]             s_axi_bresp,        // Write response
  output logic                   s_axi_bvalid,       // Write response valid
  input  wire logic              s_axi_bready,       // Write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,       // Read address
  input  wire logic [2:0]        s_axi_arprot,       // Read protection, unused
  input  wire logic              s_axi_arvalid,      // Read address valid
  output logic                   s_axi_arready,      // Read address ready
  output logic [31:0]            s_axi_rdata,        // Read data
  output logic [1:0]             s_axi_rresp,        // Read response
  output logic                   s_axi_rvalid,       // Read data valid
  input  wire logic              s_axi_rready,       // Read data ready
  input  wire logic [DAC_W-1:0]  dac_target,         // Requested DAC code
  output logic [DAC_W-1:0]       dac_code,           // Code applied to DAC
  output logic                   voltage_span_bipolar, // 1: -12 V to +12 V
  output logic                   current_limit_low,  // 1: 16 mA / 1 mA limits
  output logic                   sensor_wiring_select, // 1: 4-wire method
  output logic                   excitation_swap,    // Swap in effect
  output logic [10:0]            excitation_current_ua, // Excitation in uA
  output logic [4:0]             second_fault_code,  // Second timer code
  input  wire logic              short_detect,       // Short seen, async pin
  output logic                   first_fault_timer_active, // Tolerance running
  output logic                   second_fault_timer_start  // Pulse: start second
);

  // ==========================================================
  // Register storage
  logic [15:0] ana_reg;
  logic [15:0] sen_reg;
  logic [15:0] sw_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;

  ana_out_s    ana;
  sensor_s     sen;
  assign ana = ana_out_s'(ana_reg[`SPAN_BIT:`ILIM_BIT]);
  assign sen = sensor_s'(sen_reg[`WIRING_BIT:`EXC_SEL_LSB]);

  // ==========================================================
  // AXI4-Lite write path
  // Address and data park separately, so either may arrive first
  logic        aw_held_reg;
  logic [5:0]  aw_idx_reg;
  logic        w_held_reg;
  logic [15:0] w_data_reg;
  logic [1:0]  w_strb_reg;

  wire         aw_take   = s_axi_awvalid & ~aw_held_reg & ~bvalid_reg;
  wire         w_take    = s_axi_wvalid & ~w_held_reg & ~bvalid_reg;
  wire         wr_fire   = (aw_take | aw_held_reg) & (w_take | w_held_reg);
  wire [5:0]   wr_idx    = aw_held_reg ? aw_idx_reg : s_axi_awaddr[7:2];
  wire [1:0]   wr_strb   = w_held_reg ? w_strb_reg : s_axi_wstrb[1:0];
  wire         wr_ana    = wr_fire & (wr_idx == `ANA_OUT_IDX);
  wire         wr_sen    = wr_fire & (wr_idx == `SENSOR_IDX);
  wire         wr_sw     = wr_fire & (wr_idx == `SWITCH_IDX);
  wire         wr_hit    = wr_ana | wr_sen | wr_sw;
  wire [15:0]  byte_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire [15:0]  wdata16   = w_held_reg ? w_data_reg : s_axi_wdata[15:0];

  function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                        input logic [15:0] be, input logic [15:0] keep);
    merge = ((old_v & ~be) | (new_v & be)) & keep;
  endfunction : merge

  // A pending response blocks both channels until it is accepted
  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  // A half that arrives alone waits here for its partner
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_idx_reg  <= 6'h00;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 16'h0000;
      w_strb_reg  <= 2'h0;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        aw_idx_reg  <= s_axi_awaddr[7:2];
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[15:0];
        w_strb_reg <= s_axi_wstrb[1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ana_reg    <= `ANA_OUT_RST;
      sen_reg    <= `SENSOR_RST;
      sw_reg     <= `SWITCH_RST;
      bvalid_reg <= 1'b0;
      bresp_reg  <= 2'h0;
    end else begin
      if (wr_ana) ana_reg <= merge(ana_reg, wdata16, byte_mask, `ANA_OUT_MASK);
      if (wr_sen) sen_reg <= merge(sen_reg, wdata16, byte_mask, `SENSOR_MASK);
      if (wr_sw)  sw_reg  <= merge(sw_reg, wdata16, byte_mask, `SWITCH_MASK);
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  wire         rd_fire = s_axi_arvalid & ~rvalid_reg;
  wire [5:0]   rd_idx  = s_axi_araddr[7:2];
  wire         rd_ana  = rd_idx == `ANA_OUT_IDX;
  wire         rd_sen  = rd_idx == `SENSOR_IDX;
  wire         rd_sw   = rd_idx == `SWITCH_IDX;
  wire [15:0]  rd_mux  = rd_ana ? ana_reg : rd_sen ? sen_reg : rd_sw ? sw_reg : 16'h0000;

  assign s_axi_arready = rd_fire;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= 2'h0;
      rdata_reg  <= 32'h0000_0000;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= (rd_ana | rd_sen | rd_sw) ? 2'h0 : 2'h2;
      rdata_reg  <= {16'h0000, rd_mux};
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Slew engine
  localparam logic [DAC_W-1:0] FULL = {DAC_W{1'b1}};

  function automatic logic [DAC_W-1:0] step_of(input logic [1:0] sel);
    int unsigned pct;
    pct = 0;
    case (sel)
      2'h0:    pct = `STEP_PCT10_0;
      2'h1:    pct = `STEP_PCT10_1;
      2'h2:    pct = `STEP_PCT10_2;
      default: pct = `STEP_PCT10_3;
    endcase
    step_of = DAC_W'((int'(FULL) * pct) / 1000);
  endfunction : step_of

  function automatic int unsigned div_of(input logic [1:0] sel);
    case (sel)
      2'h0:    div_of = RATE_DIV_0;
      2'h1:    div_of = RATE_DIV_1;
      2'h2:    div_of = RATE_DIV_2;
      default: div_of = RATE_DIV_3;
    endcase
  endfunction : div_of

  logic [DAC_W-1:0] dac_reg;
  logic [31:0]      tick_cnt_reg;
  wire              slewing  = (ana.slew == SLEW_LINEAR) | (ana.slew == SLEW_HART);
  wire [1:0]        eff_step = (ana.slew == SLEW_HART) ? HART_STEP : ana.step_sel;
  wire [1:0]        eff_rate = (ana.slew == SLEW_HART) ? HART_RATE : ana.rate_sel;
  wire [31:0]       eff_div  = div_of(eff_rate);
  wire              tick     = tick_cnt_reg >= eff_div - 32'd1;
  wire [DAC_W-1:0]  step     = step_of(eff_step);
  wire              going_up = dac_target > dac_reg;
  wire [DAC_W-1:0]  gap      = going_up ? dac_target - dac_reg : dac_reg - dac_target;
  wire [DAC_W-1:0]  move     = (gap < step) ? gap : step;
  wire [DAC_W-1:0]  dac_next = going_up ? dac_reg + move : dac_reg - move;

  assign dac_code = dac_reg;

  // Off drops straight to the target; no stepped codes are produced
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_reg      <= '0;
      tick_cnt_reg <= 32'h0000_0000;
    end else if (!slewing) begin
      dac_reg      <= dac_target;
      tick_cnt_reg <= 32'h0000_0000;
    end else if (tick) begin
      dac_reg      <= dac_next;
      tick_cnt_reg <= 32'h0000_0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'd1;
    end
  end

  // ==========================================================
  // Decoded settings to the analog front end
  function automatic logic [10:0] exc_of(input logic [1:0] sel);
    case (sel)
      2'h1:    exc_of = `EXC_UA_1;
      2'h2:    exc_of = `EXC_UA_2;
      2'h3:    exc_of = `EXC_UA_3;
      default: exc_of = `EXC_UA_0;
    endcase
  endfunction : exc_of

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      voltage_span_bipolar  <= 1'b0;
      current_limit_low     <= 1'b0;
      sensor_wiring_select  <= 1'b0;
      excitation_swap       <= 1'b0;
      excitation_current_ua <= `EXC_UA_0;
      second_fault_code     <= 5'h00;
    end else begin
      voltage_span_bipolar  <= ana.span_bipolar;
      current_limit_low     <= ana.ilim_low;
      sensor_wiring_select  <= sen.four_wire;
      excitation_swap       <= sen.swap & ~sen.four_wire;
      excitation_current_ua <= exc_of(sen.exc_sel);
      second_fault_code     <= sw_reg[`T2_CODE_LSB+4:`T2_CODE_LSB];
    end
  end

  // ==========================================================
  // First fault timer
  function automatic int unsigned t1_ns(input logic [4:0] code);
    case (code)
      5'h01:   t1_ns = `T1_NS_01;
      5'h02:   t1_ns = `T1_NS_02;
      5'h03:   t1_ns = `T1_NS_03;
      5'h04:   t1_ns = `T1_NS_04;
      5'h05:   t1_ns = `T1_NS_05;
      5'h06:   t1_ns = `T1_NS_06;
      5'h07:   t1_ns = `T1_NS_07;
      5'h08:   t1_ns = `T1_NS_08;
      5'h09:   t1_ns = `T1_NS_09;
      5'h0A:   t1_ns = `T1_NS_10;
      5'h0B:   t1_ns = `T1_NS_11;
      5'h0C:   t1_ns = `T1_NS_12;
      5'h0D:   t1_ns = `T1_NS_13;
      5'h0E:   t1_ns = `T1_NS_14;
      5'h0F:   t1_ns = `T1_NS_15;
      5'h10:   t1_ns = `T1_NS_16;
      5'h11:   t1_ns = `T1_NS_17;
      5'h12:   t1_ns = `T1_NS_18;
      5'h13:   t1_ns = `T1_NS_19;
      5'h14:   t1_ns = `T1_NS_20;
      5'h15:   t1_ns = `T1_NS_21;
      default: t1_ns = `T1_NS_22;
    endcase
  endfunction : t1_ns

  logic         short_meta_reg;
  logic         short_sync_reg;
  logic [31:0]  t1_cnt_reg;
  logic         t2_start_reg;
  fault_state_e ft_state_reg;
  fault_state_e ft_next;

  wire [4:0]  t1_code   = sw_reg[`T1_CODE_LSB+4:`T1_CODE_LSB];
  wire        push_pull = sw_reg[`PUSH_PULL_BIT];
  wire        bypass    = (t1_code == 5'h00) | push_pull;
  // Longest time, so truncate; never below one cycle
  wire [31:0] t1_raw    = t1_ns(t1_code) / T1_TICK_NS;
  wire [31:0] t1_limit  = (t1_raw == 32'd0) ? 32'd1 : t1_raw;
  wire        t1_done   = t1_cnt_reg >= t1_limit - 32'd1;

  always_comb begin
    ft_next = ft_state_reg;
    case (ft_state_reg)
      FT_IDLE:    if (short_sync_reg) ft_next = bypass ? FT_EXPIRED : FT_TIMING;
      FT_TIMING:  if (!short_sync_reg) ft_next = FT_IDLE;
                  else if (bypass || t1_done) ft_next = FT_EXPIRED;
      FT_EXPIRED: if (!short_sync_reg) ft_next = FT_IDLE;
      default:    ft_next = FT_IDLE;
    endcase
  end

  assign first_fault_timer_active = ft_state_reg == FT_TIMING;
  assign second_fault_timer_start = t2_start_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      short_meta_reg <= 1'b0;
      short_sync_reg <= 1'b0;
      ft_state_reg   <= FT_IDLE;
      t1_cnt_reg     <= 32'h0000_0000;
      t2_start_reg   <= 1'b0;
    end else begin
      short_meta_reg <= short_detect;
      short_sync_reg <= short_meta_reg;
      ft_state_reg   <= ft_next;
      t1_cnt_reg     <= (ft_next == FT_TIMING) && (ft_state_reg == FT_TIMING) ?
                        t1_cnt_reg + 32'd1 : 32'h0000_0000;
      t2_start_reg   <= (ft_next == FT_EXPIRED) && (ft_state_reg != FT_EXPIRED);
    end
  end

endmodule : channel_output_and_sensor_config

// ===== verification/chan_cfg_props.sv
`timescale 1ns/1ps

// ==========================================================
// Port-level checks for the channel configuration block
module chan_cfg_props (
  input wire logic        aclk,                     // Clock
  input wire logic        aresetn,                  // Reset, low
  input wire logic        s_axi_awvalid,            // AW valid
  input wire logic        s_axi_awready,            // AW ready
  input wire logic        s_axi_wvalid,             // W valid
  input wire logic        s_axi_wready,             // W ready
  input wire logic [1:0]  s_axi_bresp,              // B resp
  input wire logic        s_axi_bvalid,             // B valid
  input wire logic        s_axi_bready,             // B ready
  input wire logic        s_axi_arvalid,            // AR valid
  input wire logic        s_axi_rvalid,             // R valid
  input wire logic        s_axi_rready,             // R ready
  input wire logic [31:0] s_axi_rdata,              // R data
  input wire logic        sensor_wiring_select,     // 4-wire
  input wire logic        excitation_swap,          // Swap
  input wire logic [10:0] excitation_current_ua,    // Current
  input wire logic        first_fault_timer_active, // Timing
  input wire logic        second_fault_timer_start  // Start pulse
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  write_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write not answered next cycle");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  read_answer_a: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  swap_gate_a: assert property (excitation_swap |-> !sensor_wiring_select)
    else $error("swap active in four-wire mode");
  exc_value_a: assert property (excitation_current_ua inside {11'd250, 11'd500, 11'd750, 11'd1000})
    else $error("excitation current off table");
  start_pulse_a: assert property ($rose(second_fault_timer_start) |=> !second_fault_timer_start)
    else $error("second timer start not one cycle");

  write_seen_c: cover property (s_axi_bvalid && s_axi_bready);
  read_seen_c: cover property (s_axi_rvalid && s_axi_rready);
  timing_seen_c: cover property ($rose(first_fault_timer_active));
  start_seen_c: cover property (second_fault_timer_start);
endmodule : chan_cfg_props

bind channel_output_and_sensor_config chan_cfg_props u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .sensor_wiring_select(sensor_wiring_select), .excitation_swap(excitation_swap),
  .excitation_current_ua(excitation_current_ua),
  .first_fault_timer_active(first_fault_timer_active),
  .second_fault_timer_start(second_fault_timer_start));

// ===== verification/channel_output_and_sensor_config_tb.sv
`timescale 1ns/1ps

`define CHECK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (e)); end end

module channel_output_and_sensor_config_tb;
  import chan_cfg_pkg::*;

  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h3;
  logic [2:0]  awprot = 3'h0;
  logic [2:0]  arprot = 3'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [13:0] target = 14'h0;
  logic        short = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, span, ilim, wiring, swap, active, start;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, got;
  logic [13:0] dac;
  logic [10:0] exc;
  logic [4:0]  t2code;
  int          num_errors = 0;
  int          check_count = 0;

  // Short divisors keep the slew and fault timers to a few cycles
  channel_output_and_sensor_config #(.RATE_DIV_0(40), .RATE_DIV_1(20), .RATE_DIV_2(12),
    .RATE_DIV_3(8), .T1_TICK_NS(2000)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(awprot),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(arprot), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .dac_target(target), .dac_code(dac), .voltage_span_bipolar(span),
    .current_limit_low(ilim), .sensor_wiring_select(wiring), .excitation_swap(swap),
    .excitation_current_ua(exc), .second_fault_code(t2code), .short_detect(short),
    .first_fault_timer_active(active), .second_fault_timer_start(start));

  always #10 aclk = ~aclk;

  // ==========================================================
  // Bus tasks
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s = 4'h3);
    awaddr <= a;
    wdata <= {16'hA5A5, d};
    wstrb <= s;
    awprot <= 3'h2;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge aclk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (!bvalid);
    // Late bready so the held response is exercised
    bready <= 1'b1;
    @(posedge aclk);
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arprot <= 3'h2;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b1;
    @(posedge aclk);
    got = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  // ==========================================================
  // Scenarios
  task automatic test_regs();
    logic [7:0]  adr[3] = '{8'h18, 8'h1C, 8'h20};
    logic [31:0] rst[3] = '{32'h0000, 32'h0001, 32'h2E00};
    logic [31:0] msk[3] = '{32'h00FF, 32'h000F, 32'h3FF1};
    `CHECK(exc, 11'd500)
    `CHECK(t2code, 5'h17)
    for (int i = 0; i < 3; i++) begin
      rd(adr[i]);
      `CHECK(got, rst[i])
      wr(adr[i], 16'hFFFF);
      rd(adr[i]);
      `CHECK(got, msk[i])
    end
    `CHECK({span, ilim, wiring, swap, exc}, {4'b1110, 11'd1000})
    wr(8'h20, 16'h0000);
    wr(8'h20, 16'hFFFF, 4'h2);
    rd(8'h20);
    `CHECK(got, 32'h3F00)
    rd(8'h24);
    `CHECK({resp, got}, {2'b10, 32'h0})
    wr(8'h24, 16'h1234);
    `CHECK(resp, 2'b10)
    wr(8'h18, 16'h0000);
    `CHECK({span, ilim}, 2'b00)
    $display("test registers done");
  endtask : test_regs

  task automatic test_sensor();
    logic [10:0] tab[4] = '{11'd250, 11'd500, 11'd750, 11'd1000};
    for (int i = 0; i < 4; i++) begin
      wr(8'h1C, 16'h0004 | 16'(i));
      `CHECK({wiring, swap, exc}, {2'b01, tab[i]})
    end
    $display("test sensor done");
  endtask : test_sensor

  task automatic slew(input logic [15:0] cfg, input logic [13:0] step, input int gap);
    int          n;
    logic [13:0] d0;
    wr(8'h18, 16'h0000);
    target <= 14'h0;
    repeat (3) @(posedge aclk);
    wr(8'h18, cfg);
    target <= 14'd2000;
    @(posedge aclk);
    d0 = dac;
    while (dac === d0) @(posedge aclk);
    `CHECK(dac, step)
    n = 0;
    d0 = dac;
    while (dac === d0) begin
      @(posedge aclk);
      n++;
    end
    `CHECK(dac, 14'(2 * step))
    `CHECK(n, gap)
    wr(8'h18, 16'h0000);
    repeat (2) @(posedge aclk);
    `CHECK(dac, 14'd2000)
    $display("test slew %0h done", cfg);
  endtask : slew

  task automatic short_run(input logic [15:0] cfg, input int lo, input int hi, input logic act);
    int   n;
    logic seen;
    wr(8'h20, cfg); // Function setup lives elsewhere; host keeps it high impedance
    short <= 1'b1;
    n = 0;
    seen = 1'b0;
    do begin
      @(posedge aclk);
      n++;
      seen |= active;
    end while (!start);
    `CHECK(n >= lo && n <= hi, 1'b1)
    `CHECK(seen, act)
    short <= 1'b0;
    repeat (6) @(posedge aclk);
    $display("test short %0h done", cfg);
  endtask : short_run

  task automatic test_reset();
    wr(8'h1C, 16'h000B);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    `CHECK({wiring, swap, exc, t2code}, {2'b00, 11'd500, 5'h17})
    rd(8'h1C);
    `CHECK(got, 32'h0001)
    $display("test reset done");
  endtask : test_reset

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // Decoded outputs settle on the first running edge
    repeat (2) @(posedge aclk);
    test_regs();
    test_sensor();
    slew(16'h002E, 14'd245, 8);
    slew(16'h0040, 14'd131, 40);
    short_run(16'h2E10, 12, 14, 1'b1);
    short_run(16'h2E00, 3, 5, 1'b0);
    short_run(16'h2E11, 3, 5, 1'b0);
    test_reset();
    finish_test();
  end

  // Whole run is a few hundred cycles
  initial begin
    #(50000 * 20);
    num_errors++;
    finish_test();
  end
endmodule : channel_output_and_sensor_config_tb
